// *** rtl/hafc_top.sv ***
// Purpose: host mac automatic flow control
// Assumes: register port is a simple word port; fifo count given in bytes
// Notes:   pause and jam requests face the switch fabric only
module hafc_top
    import hafc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             reg_cs,
    input  wire logic             reg_wr,
    input  wire logic [11:0]      reg_addr,
    input  wire logic [31:0]      reg_wdata,
    output logic      [31:0]      reg_rdata,
    output logic                  reg_ack,
    input  wire logic [CNT_W-1:0] rx_fifo_used,
    input  wire logic             rx_fifo_wr,
    input  wire logic             rx_fifo_rd,
    input  wire logic             full_duplex,
    input  wire logic             speed_10,
    input  wire logic             tx_enable,
    input  wire logic             hardwired_fc_enable,
    input  wire logic [15:0]      pause_time_value,
    input  wire logic             rx_preamble,
    input  wire logic             rx_da_valid,
    input  wire logic             rx_multicast,
    input  wire logic             rx_broadcast,
    input  wire logic             rx_own_address,
    output logic                  pause_req,
    output logic      [15:0]      pause_time,
    input  wire logic             pause_ack,
    output logic                  jam,
    output logic                  hw_fc_level
);
    // ==========================================================
    // configuration register
    logic [23:0] cfg_r;
    logic [7:0]  hi_lvl;
    logic [7:0]  lo_lvl;
    logic [3:0]  dur_code;
    logic        en_mult;
    logic        en_brd;
    logic        en_add;
    logic        en_any;
    logic        auto_en;

    assign hi_lvl   = cfg_r[HAFC_HI_MSB:HAFC_HI_LSB];
    assign lo_lvl   = cfg_r[HAFC_LO_MSB:HAFC_LO_LSB];
    assign dur_code = cfg_r[HAFC_DUR_MSB:HAFC_DUR_LSB];
    assign en_mult  = cfg_r[HAFC_MULT_BIT];
    assign en_brd   = cfg_r[HAFC_BRD_BIT];
    assign en_add   = cfg_r[HAFC_ADD_BIT];
    assign en_any   = cfg_r[HAFC_ANY_BIT];
    assign auto_en  = en_any | en_mult | en_brd | en_add;

    logic hit;
    assign hit = reg_cs && (reg_addr == HAFC_CFG_OFFSET);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= HAFC_CFG_RESET[23:0];
        end else if (hit && reg_wr) begin
            cfg_r <= reg_wdata[23:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= reg_cs;
            if (reg_cs && !reg_wr) begin
                reg_rdata <= hit ? {8'h00, cfg_r} : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // level compare
    logic [CNT_W-1:0] hi_bytes;
    logic [CNT_W-1:0] lo_bytes;
    logic             above_hi_r;
    logic             below_lo_r;

    assign hi_bytes = CNT_W'({hi_lvl, 6'h00});
    assign lo_bytes = CNT_W'({lo_lvl, 6'h00});

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            above_hi_r <= 1'b0;
            below_lo_r <= 1'b1;
        end else if (rx_fifo_wr || rx_fifo_rd) begin
            above_hi_r <= (rx_fifo_used >= hi_bytes);
            below_lo_r <= (rx_fifo_used < lo_bytes);
        end
    end

    // hard-wired flow control level, high to low hysteresis
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hw_fc_level <= 1'b0;
        end else if (!hardwired_fc_enable || !tx_enable) begin
            hw_fc_level <= 1'b0;
        end else if (above_hi_r) begin
            hw_fc_level <= 1'b1;
        end else if (below_lo_r) begin
            hw_fc_level <= 1'b0;
        end
    end

    // ==========================================================
    // full duplex pause sequencer
    hafc_state_t state_r;
    logic        fd_active;

    assign fd_active = full_duplex && en_any && tx_enable;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= HAFC_IDLE;
            pause_req  <= 1'b0;
            pause_time <= 16'h0000;
        end else if (pause_req) begin
            if (pause_ack) begin
                pause_req <= 1'b0;
            end
        end else begin
            case (state_r)
                HAFC_IDLE: begin
                    if (fd_active && above_hi_r) begin
                        pause_req  <= 1'b1;
                        pause_time <= pause_time_value;
                        state_r    <= HAFC_PAUSED;
                    end
                end
                HAFC_PAUSED: begin
                    if (below_lo_r && auto_en && tx_enable) begin
                        pause_req  <= 1'b1;
                        pause_time <= 16'h0000;
                        state_r    <= HAFC_DONE;
                    end else if (!auto_en) begin
                        state_r <= HAFC_IDLE;
                    end
                end
                HAFC_DONE: begin
                    state_r <= HAFC_IDLE;
                end
                default: begin
                    state_r <= HAFC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // half duplex jam
    logic [5:0] tick_cnt_r;
    logic       tick_en;
    logic       bp_start;
    logic       bp_active;
    logic       match;
    logic       hd_ok;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= 6'h00;
        end else if (tick_cnt_r == 6'(HAFC_TICK_CYC - 1)) begin
            tick_cnt_r <= 6'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 6'h01;
        end
    end
    assign tick_en = (tick_cnt_r == 6'(HAFC_TICK_CYC - 1));

    assign hd_ok = !full_duplex && tx_enable && above_hi_r && !bp_active;
    assign match = en_any ? rx_preamble
                 : rx_da_valid && ((en_mult && rx_multicast)
                                || (en_brd && rx_broadcast)
                                || (en_add && rx_own_address));
    assign bp_start = hd_ok && match;

    hafc_bp_timer u_bp_timer (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .tick_en  (tick_en),
        .start    (bp_start),
        .code     (dur_code),
        .speed_10 (speed_10),
        .active   (bp_active)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            jam <= 1'b0;
        end else begin
            jam <= (bp_active || bp_start) && tx_enable && !full_duplex;
        end
    end
endmodule

// *** rtl/hafc_pkg.sv ***
// Purpose: constants for host mac automatic flow control
// Assumes: 10 MHz sys_clk, register port as a plain word access port
// Notes:   none
package hafc_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] HAFC_CFG_OFFSET = 12'h0_0ac;
    localparam logic [31:0] HAFC_CFG_RESET  = 32'h0000_0000;
    localparam int HAFC_HI_MSB  = 23;
    localparam int HAFC_HI_LSB  = 16;
    localparam int HAFC_LO_MSB  = 15;
    localparam int HAFC_LO_LSB  = 8;
    localparam int HAFC_DUR_MSB = 7;
    localparam int HAFC_DUR_LSB = 4;
    localparam int HAFC_MULT_BIT = 3;
    localparam int HAFC_BRD_BIT  = 2;
    localparam int HAFC_ADD_BIT  = 1;
    localparam int HAFC_ANY_BIT  = 0;
    localparam int HAFC_UNIT_SHIFT = 6;
    // ==========================================================
    // timing
    localparam int HAFC_CLK_MHZ        = 10;
    localparam int HAFC_SLOW_EXTRA_NS  = 2200;
    localparam int HAFC_SLOW_EXTRA_CYC = (HAFC_SLOW_EXTRA_NS * HAFC_CLK_MHZ + 999) / 1000;
    localparam int HAFC_TICK_US        = 5;
    localparam int HAFC_TICK_CYC       = HAFC_TICK_US * HAFC_CLK_MHZ;
    // ==========================================================
    // pause sequencer states
    typedef enum logic [2:0] {
        HAFC_IDLE  = 3'b001,
        HAFC_PAUSED = 3'b010,
        HAFC_DONE  = 3'b100
    } hafc_state_t;
endpackage

// *** rtl/hafc_bp_timer.sv ***
// Purpose: back-pressure duration timer
// Assumes: 5 us tick enable from the top
// Notes:   none
module hafc_bp_timer
    import hafc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       tick_en,
    input  wire logic       start,
    input  wire logic [3:0] code,
    input  wire logic       speed_10,
    output logic            active
);
    // ==========================================================
    // duration in 5 us ticks
    function automatic logic [6:0] ticks_of(input logic [3:0] c);
        logic [6:0] t;
        t = 7'h00;
        case (c)
            4'h0: t = 7'h01;
            4'h1: t = 7'h02;
            4'h2: t = 7'h03;
            4'h3: t = 7'h05;
            4'h4: t = 7'h0a;
            default: t = 7'(({3'b000, c} - 7'h03) * 7'h0a);
        endcase
        return t;
    endfunction

    logic [6:0] tick_cnt_r;
    logic [4:0] extra_cnt_r;
    logic       ext_phase_r;

    // ==========================================================
    // countdown
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r  <= 7'h00;
            extra_cnt_r <= 5'h00;
            ext_phase_r <= 1'b0;
            active      <= 1'b0;
        end else if (start) begin
            tick_cnt_r  <= ticks_of(code);
            extra_cnt_r <= speed_10 ? 5'(HAFC_SLOW_EXTRA_CYC) : 5'h00;
            ext_phase_r <= 1'b0;
            active      <= 1'b1;
        end else if (active) begin
            if (!ext_phase_r) begin
                if (tick_en) begin
                    if (tick_cnt_r <= 7'h01) begin
                        ext_phase_r <= 1'b1;
                        if (extra_cnt_r == 5'h00) begin
                            active <= 1'b0;
                        end
                    end
                    tick_cnt_r <= tick_cnt_r - 7'h01;
                end
            end else if (extra_cnt_r <= 5'h01) begin
                extra_cnt_r <= 5'h00;
                active      <= 1'b0;
            end else begin
                extra_cnt_r <= extra_cnt_r - 5'h01;
            end
        end
    end
endmodule

// *** bench/hafc_asserts.sv ***
// Purpose: port checks for hafc_top
// Assumes: one clock, active-low reset
// Notes:   attached by bind
module hafc_asserts (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        reg_cs,
    input wire logic        reg_ack,
    input wire logic        full_duplex,
    input wire logic        tx_enable,
    input wire logic        hardwired_fc_enable,
    input wire logic        rx_preamble,
    input wire logic        rx_da_valid,
    input wire logic        pause_req,
    input wire logic [15:0] pause_time,
    input wire logic        pause_ack,
    input wire logic        jam,
    input wire logic        hw_fc_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_ack_follows: assert property (reg_cs |=> reg_ack) else $error("no ack");
    a_ack_alone: assert property (!reg_cs |=> !reg_ack) else $error("stray ack");
    a_pause_hold: assert property (pause_req && !pause_ack |=> pause_req && $stable(pause_time))
        else $error("pause lost");
    a_pause_drop: assert property (pause_req && pause_ack |=> !pause_req) else $error("no drop");
    a_pause_tx: assert property ($rose(pause_req) |-> $past(tx_enable)) else $error("tx off pause");
    a_tx_quiet: assert property (!tx_enable && !$past(tx_enable) |-> !jam && !hw_fc_level)
        else $error("tx off jam");
    a_jam_half: assert property ($rose(jam) |-> !$past(full_duplex) &&
        ($past(rx_preamble) || $past(rx_da_valid))) else $error("bad jam");
    a_hw_gate: assert property ($rose(hw_fc_level) |-> $past(hardwired_fc_enable)) else $error("hw gate");
endmodule
bind hafc_top hafc_asserts u_chk (.*);

// *** bench/hafc_fab_xmit.sv ***
// Purpose: fabric side transmitter taking pause requests
// Assumes: slow selects a late answer
// Notes:   ack is a one-cycle pulse
module hafc_fab_xmit (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pause_req,
    input  wire logic slow,
    output logic      pause_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 4'h0;
            pause_ack <= 1'b0;
        end else begin
            wait_r <= (pause_req && !pause_ack) ? wait_r + 4'h1 : 4'h0;
            pause_ack <= pause_req && !pause_ack && wait_r == (slow ? 4'h8 : 4'h1);
        end
    end
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for hafc_top
// Assumes: inputs move on the falling edge
// Notes:   short jam codes keep the run brief
module tb_top;
    import hafc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, resetn = 0, reg_cs = 0, reg_wr = 0, slow = 1, tx_enable = 0, full_duplex = 1;
    logic        rx_fifo_wr = 0, rx_fifo_rd = 0, rx_preamble = 0, rx_da_valid = 0, speed_10 = 0;
    logic        rx_multicast = 0, rx_broadcast = 0, rx_own_address = 0, hardwired_fc_enable = 0;
    logic        reg_ack, pause_req, pause_ack, jam, hw_fc_level;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd;
    logic [15:0] rx_fifo_used = 0, pause_time_value = 16'h1234, pause_time;
    int          err_total = 0, compares = 0, cycles = 0, n;
    hafc_top DUT (.*);
    hafc_fab_xmit u_fab (.*);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cycles == 20000) begin
        err_total = err_total + 1;
        close_out();
    end
    task automatic close_out();
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) $display("[ERR] %s exp %h got %h", what, exp, got);
        if (got !== exp) err_total++;
    endtask
    task automatic reg_io(logic wr, logic [11:0] a, logic [31:0] d);
        @(negedge sys_clk);
        {reg_cs, reg_wr, reg_addr, reg_wdata} = {1'b1, wr, a, d};
        @(negedge sys_clk);
        reg_cs = 1'b0;
        rd = reg_rdata;
    endtask
    task automatic drv(logic [15:0] used, logic [6:0] s);
        @(negedge sys_clk);
        rx_fifo_used = used;
        {rx_fifo_wr, rx_fifo_rd, rx_preamble, rx_da_valid, rx_multicast, rx_broadcast, rx_own_address} = s;
        @(negedge sys_clk);
        {rx_fifo_wr, rx_fifo_rd, rx_preamble, rx_da_valid} = 4'h0;
    endtask
    task automatic wait_for(logic s, logic lvl, int lim);
        for (n = 0; n < lim && (s ? jam : pause_req) !== lvl; n++) @(negedge sys_clk);
    endtask
    task automatic t_reg();
        reg_io(1, HAFC_CFG_OFFSET, 32'hA504_021F);
        reg_io(0, HAFC_CFG_OFFSET, '0);
        chk("cfg", 32'h0004_021F, rd);
        reg_io(0, 12'h0_0a8, '0);
        chk("unmapped", 32'h0000_0000, rd);
    endtask
    task automatic t_fd();
        tx_enable = 1;
        reg_io(1, HAFC_CFG_OFFSET, 32'h0004_0201);
        drv(16'h0100, 7'h40);
        wait_for(0, 1, 10);
        chk("pause", 32'h0001_1234, {pause_req, pause_time});
        wait_for(0, 0, 20);
        drv(16'h0200, 7'h40);
        chk("one pause", 0, pause_req);
        drv(16'h007F, 7'h20);
        wait_for(0, 1, 10);
        chk("zero pause", 32'h0001_0000, {pause_req, pause_time});
    endtask
    task automatic t_hd();
        full_duplex = 0;
        hardwired_fc_enable = 1;
        drv(16'h0100, 7'h40);
        for (int i = 0; i < 4; i++) begin
            reg_io(1, HAFC_CFG_OFFSET, 32'h0004_0200 | (32'h1 << i));
            drv(16'h0100, {3'b000, i != 0, ~3'(4'h1 << i >> 1)});
            wait_for(1, 1, 5);
            rd[1] = jam;
            drv(16'h0100, {2'b00, i == 0, i != 0, 3'(4'h1 << i >> 1)});
            wait_for(1, 1, 5);
            rd[0] = jam;
            chk("jam mode", 2'b01, rd[1:0]);
            wait_for(1, 0, 60);
        end
        chk("hw level", 1, hw_fc_level);
        speed_10 = 1;
        reg_io(1, HAFC_CFG_OFFSET, 32'h0004_0211);
        drv(16'h0100, 7'h10);
        wait_for(1, 1, 5);
        wait_for(1, 0, 200);
        chk("jam length", 1, n >= 72 && n <= 124);
        speed_10 = 0;
        reg_io(1, HAFC_CFG_OFFSET, 32'h0004_0251);
        drv(16'h0100, 7'h10);
        wait_for(1, 1, 5);
        wait_for(1, 0, 1100);
        chk("long jam", 1, n >= 950 && n <= 1002);
    endtask
    task automatic t_quiet();
        tx_enable = 0;
        drv(16'h0100, 7'h10);
        chk("tx off jam", 0, jam);
        chk("tx off level", 0, hw_fc_level);
        full_duplex = 1;
        drv(16'h0100, 7'h40);
        wait_for(0, 1, 5);
        chk("tx off pause", 0, pause_req);
        drv(16'h007F, 7'h20);
        tx_enable = 1;
        wait_for(0, 1, 5);
        chk("no early zero", 0, pause_req);
        full_duplex = 0;
        drv(16'h00C0, 7'h40);
        @(negedge sys_clk);
        chk("hw mid low", 0, hw_fc_level);
        drv(16'h0100, 7'h40);
        @(negedge sys_clk);
        chk("hw on", 1, hw_fc_level);
        drv(16'h00C0, 7'h20);
        @(negedge sys_clk);
        chk("hw held", 1, hw_fc_level);
        drv(16'h007F, 7'h20);
        @(negedge sys_clk);
        chk("hw off", 0, hw_fc_level);
    endtask
    task automatic t_rst();
        drv(16'h0100, 7'h40);
        @(negedge sys_clk);
        resetn = 0;
        repeat (3) @(negedge sys_clk);
        resetn = 1;
        chk("rst outputs", 0, {jam, hw_fc_level, pause_req});
        reg_io(0, HAFC_CFG_OFFSET, '0);
        chk("rst cfg", 0, rd);
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        resetn = 1;
        t_reg();
        t_fd();
        t_hd();
        t_quiet();
        t_rst();
        close_out();
    end
endmodule
